// File: hw/charger_regs_pkg.sv
// Package: register offsets, field positions, reset values and shared types
package charger_regs_pkg;

  // Byte addresses on the host register port
  localparam logic [7:0] ADDR_INPUT_LIMIT_LOW = 8'h24;
  localparam logic [7:0] ADDR_INPUT_LIMIT_HIGH = 8'h25;
  localparam logic [7:0] ADDR_SYSTEM_POWER = 8'h26;
  localparam logic [7:0] ADDR_BUS_VOLTAGE = 8'h27;
  localparam logic [7:0] ADDR_DISCHARGE_CURRENT = 8'h28;
  localparam logic [7:0] ADDR_CHARGE_CURRENT = 8'h29;
  localparam logic [7:0] ADDR_COMPARATOR_INPUT = 8'h2A;
  localparam logic [7:0] ADDR_INPUT_CURRENT = 8'h2B;
  localparam logic [7:0] ADDR_BATTERY_VOLTAGE = 8'h2C;
  localparam logic [7:0] ADDR_SYSTEM_VOLTAGE = 8'h2D;
  localparam logic [7:0] ADDR_OPTION_ONE_LOW = 8'h30;
  localparam logic [7:0] ADDR_OPTION_ONE_HIGH = 8'h31;

  // Reset value of the first charge-option register
  localparam logic [15:0] OPTION_ONE_RESET = 16'h3F00;

  // Field positions in the option high byte
  localparam int BIT_MONITOR_ENABLE = 7;
  localparam int BIT_ALERT_ENABLE = 6;
  localparam int BIT_SENSE_CFG_HI = 5;
  localparam int BIT_SENSE_CFG_LO = 4;
  localparam int BIT_INPUT_SENSE = 3;
  localparam int BIT_CHARGE_SENSE = 2;
  localparam int BIT_SENSE_GAIN = 1;
  localparam int BIT_FAST_COMP = 0;

  // Reserved readbacks
  localparam logic [7:0] RESERVED_READ = 8'h00;
  localparam logic [7:0] CURRENT_FIELD_MASK = 8'h7F;

  // Scaling: mV / mA per code, zero offsets in mV, full-scale code, gain in nA per W, clamp in mA
  localparam int BUS_STEP_MV = 96;
  localparam int BUS_SPAN_MV = 24480;
  localparam int SPAN_WIDE_STEP_MV = 12;
  localparam int SPAN_NARROW_STEP_MV = 8;
  localparam int CHARGE_STEP_10_MA = 64;
  localparam int CHARGE_STEP_5_MA = 128;
  localparam int DISCHARGE_STEP_10_MA = 256;
  localparam int DISCHARGE_STEP_5_MA = 512;
  localparam int INPUT_STEP_10_MA = 50;
  localparam int INPUT_STEP_5_MA = 100;
  localparam int CELL_STEP_MV = 64;
  localparam int CELL_ZERO_LOW_MV = 2880;
  localparam int CELL_ZERO_FIVE_MV = 8160;
  localparam int DISCHARGE_FULL_CODE = 127;
  localparam int GAIN_LOW_NA_PER_W = 250;
  localparam int GAIN_HIGH_NA_PER_W = 1000;
  localparam int FAST_CLAMP_MA = 6400;

  // Power-sense configuration codes
  typedef enum logic [1:0] {
    SENSE_BUS_AND_BATTERY = 2'b00,
    SENSE_BUS_ONLY = 2'b01,
    SENSE_RESERVED = 2'b10,
    SENSE_OFF = 2'b11
  } power_sense_cfg_t;

  // One completed conversion set from the converter
  typedef struct packed {
    logic [7:0] system_power;
    logic [7:0] bus_voltage;
    logic [6:0] discharge_current;
    logic [6:0] charge_current;
    logic [7:0] comparator_input;
    logic [7:0] input_current;
    logic [7:0] battery_voltage;
    logic [7:0] system_voltage;
  } adc_results_t;

  // Decoded option high byte driving the analogue side
  typedef struct packed {
    logic current_monitor_buffer_enable;
    logic low_power_alert_enable;
    power_sense_cfg_t power_sense_config;
    logic input_sense_resistor_select;
    logic charge_sense_resistor_select;
    logic power_sense_gain;
    logic fast_compensation_enable;
  } option_controls_t;

  // Scaling published to the analogue/readout side
  typedef struct packed {
    logic [15:0] charge_step_ma;
    logic [15:0] discharge_step_ma;
    logic [15:0] input_step_ma;
    logic [15:0] span_step_mv;
    logic [15:0] cell_zero_mv;
    logic [15:0] discharge_full_ma;
    logic [15:0] bus_step_mv;
    logic [15:0] gain_na_per_w;
    logic [15:0] input_clamp_ma;
  } scaling_t;

  // Shared step selection by a one-bit choice
  function automatic logic [15:0] pick_step(input logic sel, input int when_zero, input int when_one);
    pick_step = sel ? 16'(when_one) : 16'(when_zero);
  endfunction

endpackage

// File: hw/adc_result_store.sv
// Holding registers for the most recent completed conversion set
`timescale 1ns/100ps
module adc_result_store
  import charger_regs_pkg::*;
(
  // Clock and control
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Conversion input
  input wire logic i_done,
  input wire adc_results_t i_results,
  // Stored results
  output adc_results_t o_results
);

  // Capture only on completion; reads never touch this store
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_results <= '0;
    end else if (i_clk_en && i_done) begin
      o_results <= i_results;
    end
  end

endmodule

// File: hw/option_decode.sv
// Decode of the option high byte into analogue enables and scaling
`timescale 1ns/100ps
module option_decode
  import charger_regs_pkg::*;
(
  // Option state
  input wire option_controls_t i_opt,
  input wire logic i_low_power_mode_enable,
  input wire logic i_adc_span_select,
  input wire logic i_five_cells,
  // Analogue enables
  output logic o_current_monitor_on,
  output logic o_power_sense_on,
  output logic o_power_sense_battery,
  output logic o_low_power_alert_on,
  // Scaling
  output scaling_t o_scale
);

  // Low-power mode overrides both buffer enables
  always_comb begin
    o_current_monitor_on = i_opt.current_monitor_buffer_enable && !i_low_power_mode_enable;
    o_power_sense_on = !i_low_power_mode_enable &&
      (i_opt.power_sense_config == SENSE_BUS_AND_BATTERY || i_opt.power_sense_config == SENSE_BUS_ONLY);
    o_power_sense_battery = o_power_sense_on && (i_opt.power_sense_config == SENSE_BUS_AND_BATTERY);
    // Alert monitoring only meaningful on battery in low-power mode
    o_low_power_alert_on = i_opt.low_power_alert_enable && i_low_power_mode_enable;
  end

  // Per-code scaling chosen by the sense selections, span and cell count
  always_comb begin
    o_scale.charge_step_ma = pick_step(i_opt.charge_sense_resistor_select,
      CHARGE_STEP_10_MA, CHARGE_STEP_5_MA);
    o_scale.discharge_step_ma = pick_step(i_opt.charge_sense_resistor_select,
      DISCHARGE_STEP_10_MA, DISCHARGE_STEP_5_MA);
    o_scale.input_step_ma = pick_step(i_opt.input_sense_resistor_select,
      INPUT_STEP_10_MA, INPUT_STEP_5_MA);
    o_scale.span_step_mv = pick_step(i_adc_span_select, SPAN_NARROW_STEP_MV, SPAN_WIDE_STEP_MV);
    o_scale.cell_zero_mv = pick_step(i_five_cells, CELL_ZERO_LOW_MV, CELL_ZERO_FIVE_MV);
    o_scale.discharge_full_ma = 16'(DISCHARGE_FULL_CODE * 256) << i_opt.charge_sense_resistor_select;
    o_scale.bus_step_mv = 16'(BUS_STEP_MV);
    o_scale.gain_na_per_w = pick_step(i_opt.power_sense_gain, GAIN_LOW_NA_PER_W, GAIN_HIGH_NA_PER_W);
    // Fast compensation under 5 mOhm input sensing clamps the limit
    o_scale.input_clamp_ma = (i_opt.fast_compensation_enable && i_opt.input_sense_resistor_select)
      ? 16'(FAST_CLAMP_MA) : 16'hFFFF;
  end

endmodule

// File: hw/charger_adc_results_option_regs.sv
// Register bank: ADC result readback and option high byte of the charger
`timescale 1ns/100ps
module charger_adc_results_option_regs
  import charger_regs_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Host register port (byte wide, one cycle strobes)
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Converter side
  input wire logic i_adc_done,
  input wire adc_results_t i_adc_results,
  input wire logic [6:0] i_input_limit_code,
  input wire logic i_discharge_over_range,
  // Device modes held elsewhere
  input wire logic i_low_power_mode_enable,
  input wire logic i_adc_span_select,
  input wire logic i_five_cells,
  input wire logic [7:0] i_option_low,
  // Analogue controls
  output option_controls_t o_option,
  output logic o_current_monitor_on,
  output logic o_power_sense_on,
  output logic o_power_sense_battery,
  output logic o_low_power_alert_on,
  output scaling_t o_scale
);

  logic [7:0] option_high;
  adc_results_t incoming;
  adc_results_t stored;
  logic [7:0] next_rdata;

  // Discharge code saturates at full scale when the converter is over range
  always_comb begin
    incoming = i_adc_results;
    if (i_discharge_over_range) begin
      incoming.discharge_current = 7'(DISCHARGE_FULL_CODE);
    end
  end

  adc_result_store u_store (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_done(i_adc_done),
    .i_results(incoming),
    .o_results(stored)
  );

  // Option high byte; power-on defaults set all sense selections
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      option_high <= OPTION_ONE_RESET[15:8];
    end else if (i_clk_en && i_reg_write && i_reg_addr == ADDR_OPTION_ONE_HIGH) begin
      option_high <= i_reg_wdata;
    end
  end

  // Fast compensation bit follows bit 0 of the option byte as written, like the other fields
  always_comb begin
    o_option.current_monitor_buffer_enable = option_high[BIT_MONITOR_ENABLE];
    o_option.low_power_alert_enable = option_high[BIT_ALERT_ENABLE];
    o_option.power_sense_config = power_sense_cfg_t'(option_high[BIT_SENSE_CFG_HI:BIT_SENSE_CFG_LO]);
    o_option.input_sense_resistor_select = option_high[BIT_INPUT_SENSE];
    o_option.charge_sense_resistor_select = option_high[BIT_CHARGE_SENSE];
    o_option.power_sense_gain = option_high[BIT_SENSE_GAIN];
    o_option.fast_compensation_enable = option_high[BIT_FAST_COMP];
  end

  option_decode u_decode (
    .i_opt(o_option),
    .i_low_power_mode_enable(i_low_power_mode_enable),
    .i_adc_span_select(i_adc_span_select),
    .i_five_cells(i_five_cells),
    .o_current_monitor_on(o_current_monitor_on),
    .o_power_sense_on(o_power_sense_on),
    .o_power_sense_battery(o_power_sense_battery),
    .o_low_power_alert_on(o_low_power_alert_on),
    .o_scale(o_scale)
  );

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (i_reg_addr)
      ADDR_INPUT_LIMIT_LOW: next_rdata = RESERVED_READ;
      ADDR_INPUT_LIMIT_HIGH: next_rdata = {1'b0, i_input_limit_code};
      ADDR_SYSTEM_POWER: next_rdata = stored.system_power;
      ADDR_BUS_VOLTAGE: next_rdata = stored.bus_voltage;
      ADDR_DISCHARGE_CURRENT: next_rdata = {1'b0, stored.discharge_current} & CURRENT_FIELD_MASK;
      ADDR_CHARGE_CURRENT: next_rdata = {1'b0, stored.charge_current} & CURRENT_FIELD_MASK;
      ADDR_COMPARATOR_INPUT: next_rdata = stored.comparator_input;
      ADDR_INPUT_CURRENT: next_rdata = stored.input_current;
      ADDR_BATTERY_VOLTAGE: next_rdata = stored.battery_voltage;
      ADDR_SYSTEM_VOLTAGE: next_rdata = stored.system_voltage;
      ADDR_OPTION_ONE_LOW: next_rdata = i_option_low;
      ADDR_OPTION_ONE_HIGH: next_rdata = option_high;
      default: next_rdata = RESERVED_READ;
    endcase
  end

  // Registered read data; a read has no effect on stored results
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_reg_rdata <= '0;
      o_reg_rvalid <= 1'b0;
    end else if (i_clk_en) begin
      o_reg_rvalid <= i_reg_read;
      if (i_reg_read) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

endmodule

// File: tb/charger_regs_monitor.sv
// Checker: port-level properties of the charger result and option register bank
`timescale 1ns/100ps
module charger_regs_monitor
  import charger_regs_pkg::*;
(
  // Clock and control
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Host register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // Modes and controls
  input wire logic i_low_power_mode_enable,
  input wire logic i_adc_span_select,
  input wire logic i_five_cells,
  input wire option_controls_t o_option,
  input wire logic o_current_monitor_on,
  input wire logic o_power_sense_on,
  input wire scaling_t o_scale
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // Steps of a host access: the edge that takes it
  sequence s_read;
    i_reg_read && i_clk_en;
  endsequence
  sequence s_opt_write;
    i_reg_write && i_clk_en && i_reg_addr == 8'h31;
  endsequence
  property p_read_answer; s_read |=> o_reg_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  // A frozen edge keeps the old answer, so only a running edge without a read must clear it
  property p_no_answer; i_clk_en && !i_reg_read |=> !o_reg_rvalid; endproperty
  a_no_answer: assert property (p_no_answer) else $error("answer without read");
  property p_freeze; !i_clk_en |=> $stable(o_reg_rvalid) && $stable(o_reg_rdata) && $stable(o_option); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");
  property p_limit_low; s_read ##0 (i_reg_addr == 8'h24) |=> o_reg_rdata == 8'h00; endproperty
  a_limit_low: assert property (p_limit_low) else $error("limit low byte not zero");
  property p_current_top; s_read ##0 (i_reg_addr[7:1] == 7'h14) |=> !o_reg_rdata[7]; endproperty
  a_current_top: assert property (p_current_top) else $error("current byte top bit set");
  property p_opt_write; s_opt_write |=> o_option == $past(i_reg_wdata); endproperty
  a_opt_write: assert property (p_opt_write) else $error("option write lost");
  property p_opt_hold; !(i_reg_write && i_clk_en && i_reg_addr == 8'h31) |=> $stable(o_option); endproperty
  a_opt_hold: assert property (p_opt_hold) else $error("option changed unasked");
  property p_monitor; o_current_monitor_on == (o_option[7] && !i_low_power_mode_enable); endproperty
  a_monitor: assert property (p_monitor) else $error("monitor buffer enable wrong");
  property p_sense; o_power_sense_on == (!o_option[5] && !i_low_power_mode_enable); endproperty
  a_sense: assert property (p_sense) else $error("power sense enable wrong");
  property p_charge_step; o_scale.charge_step_ma == (o_option[2] ? 16'h0080 : 16'h0040); endproperty
  a_charge_step: assert property (p_charge_step) else $error("charge step wrong");
  property p_cell; o_scale.cell_zero_mv == (i_five_cells ? 16'h1FE0 : 16'h0B40); endproperty
  a_cell: assert property (p_cell) else $error("cell zero wrong");
  property p_span; o_scale.span_step_mv == (i_adc_span_select ? 16'h000C : 16'h0008); endproperty
  a_span: assert property (p_span) else $error("span step wrong");
endmodule

bind charger_adc_results_option_regs charger_regs_monitor u_mon (.i_core_clk, .i_reset, .i_clk_en,
  .i_reg_addr, .i_reg_write, .i_reg_read, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
  .i_low_power_mode_enable, .i_adc_span_select, .i_five_cells, .o_option, .o_current_monitor_on,
  .o_power_sense_on, .o_scale);

// File: tb/charger_adc_results_option_regs_test.sv
// Testbench: randomised readback and option checks of the charger register bank
`timescale 1ns/100ps
module charger_adc_results_option_regs_test;
  import charger_regs_pkg::*;
  logic i_core_clk = 0, i_reset = 1, i_clk_en = 1, i_reg_write = 0, i_reg_read = 0, i_adc_done = 0;
  logic i_discharge_over_range = 0, i_low_power_mode_enable = 0, i_adc_span_select = 0, i_five_cells = 0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_option_low = 8'h5A, o_reg_rdata, opt;
  logic [6:0] i_input_limit_code = 7'h00;
  logic o_reg_rvalid, o_current_monitor_on, o_power_sense_on, o_power_sense_battery, o_low_power_alert_on;
  logic held_ovr;
  adc_results_t i_adc_results = '0, held;
  option_controls_t o_option;
  scaling_t o_scale;
  int n_mismatch = 0, samples_checked = 0, seed = 91172;

  charger_adc_results_option_regs DUT (.i_core_clk, .i_reset, .i_clk_en, .i_reg_addr, .i_reg_write,
    .i_reg_read, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_adc_done, .i_adc_results,
    .i_input_limit_code, .i_discharge_over_range, .i_low_power_mode_enable, .i_adc_span_select,
    .i_five_cells, .i_option_low, .o_option, .o_current_monitor_on, .o_power_sense_on,
    .o_power_sense_battery, .o_low_power_alert_on, .o_scale);

  // 100 MHz core clock
  always #5 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Readback expected from the last captured set; reserved places read zero
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h25: exp_rd = {1'b0, i_input_limit_code};
      8'h26: exp_rd = held.system_power;
      8'h27: exp_rd = held.bus_voltage;
      8'h28: exp_rd = held_ovr ? 8'h7F : {1'b0, held.discharge_current};
      8'h29: exp_rd = {1'b0, held.charge_current};
      8'h2A: exp_rd = held.comparator_input;
      8'h2B: exp_rd = held.input_current;
      8'h2C: exp_rd = held.battery_voltage;
      8'h2D: exp_rd = held.system_voltage;
      8'h30: exp_rd = i_option_low;
      8'h31: exp_rd = opt;
      default: exp_rd = 8'h00;
    endcase
  endfunction

  task automatic rd(input logic [7:0] a);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_core_clk);
    i_reg_read <= 1'b0;
    #1;
    chk(o_reg_rvalid, 1);
    chk(o_reg_rdata, exp_rd(a));
  endtask

  // Only the option high byte takes writes; the model follows that alone
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_wdata <= v;
    i_reg_write <= 1'b1;
    @(posedge i_core_clk);
    i_reg_write <= 1'b0;
    if (a == 8'h31) opt = v;
  endtask

  task automatic chk_out;
    logic lp;
    lp = i_low_power_mode_enable;
    chk(o_option, opt);
    chk(o_current_monitor_on, opt[7] & !lp);
    chk(o_power_sense_on, !opt[5] & !lp);
    chk(o_power_sense_battery, (opt[5:4] == 2'b00) & !lp);
    chk(o_low_power_alert_on, opt[6] & lp);
    chk(o_scale.charge_step_ma, 16'(opt[2] ? CHARGE_STEP_5_MA : CHARGE_STEP_10_MA));
    chk(o_scale.discharge_step_ma, 16'(opt[2] ? DISCHARGE_STEP_5_MA : DISCHARGE_STEP_10_MA));
    chk(o_scale.discharge_full_ma, 16'(opt[2] ? 65024 : 32512));
    chk(o_scale.input_step_ma, 16'(opt[3] ? INPUT_STEP_5_MA : INPUT_STEP_10_MA));
    chk(o_scale.span_step_mv, 16'(i_adc_span_select ? 12 : 8));
    chk(o_scale.cell_zero_mv, 16'(i_five_cells ? 8160 : 2880));
    chk(o_scale.bus_step_mv, 16'(96));
    chk(o_scale.gain_na_per_w, 16'(opt[1] ? 1000 : 250));
    chk(o_scale.input_clamp_ma, (opt[0] & opt[3]) ? 16'(FAST_CLAMP_MA) : 16'hFFFF);
  endtask

  // Main sequence: reset defaults, then random conversions and option writes
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_reset <= 1'b0;
    held = '0;
    held_ovr = 1'b0;
    opt = 8'h3F;
    #1;
    chk_out;
    chk(o_option.fast_compensation_enable, 1);
    for (int a = 8'h24; a <= 8'h31; a++) rd(a[7:0]);
    for (int i = 0; i < 40; i++) begin
      @(posedge i_core_clk);
      i_adc_results <= (i == 0) ? '1 : adc_results_t'({$random(seed), $random(seed)});
      i_discharge_over_range <= (i < 2) ? i[0] : 1'($random(seed));
      i_clk_en <= (i % 5 != 4);
      i_adc_done <= 1'b1;
      i_input_limit_code <= 7'($random(seed));
      i_option_low <= 8'($random(seed));
      {i_low_power_mode_enable, i_adc_span_select, i_five_cells} <= 3'($random(seed));
      @(posedge i_core_clk);
      i_adc_done <= 1'b0;
      i_clk_en <= 1'b1;
      // A frozen edge must not capture: only update the model when the enable was up
      if (i_clk_en) held = i_adc_results;
      if (i_clk_en) held_ovr = i_discharge_over_range;
      wr((i % 4 == 3) ? 8'h29 : 8'h31, (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : 8'($random(seed)));
      #1;
      chk_out;
      for (int a = 8'h24; a <= 8'h31; a++) rd(a[7:0]);
      rd(8'h29);
      rd(8'h40);
    end
    // Second reset in mid-run: defaults come back, results clear
    @(posedge i_core_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'b0;
    held = '0;
    held_ovr = 1'b0;
    opt = 8'h3F;
    #1;
    chk(o_reg_rvalid, 0);
    chk(o_reg_rdata, 0);
    chk_out;
    rd(8'h26);
    rd(8'h28);
    rd(8'h31);
    complete_run;
  end

  // Guard against a hang of the main sequence
  initial begin
    #200_000;
    n_mismatch++;
    complete_run;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
endmodule
